// [sleep_unit_defines.vh]
/*
 Constants for the sleep unit: register offset, field positions, mode codes,
 wake source indices and wake-up timing. Assumes inclusion by bare name.
*/
// Operation
// - Idle halts the core; all peripherals and their clocks keep running.
// - Idle: any enabled interrupt wakes the device.
// - Standby: a peripheral clock runs only if its run_in_standby is set.
// - Standby wakes on pin, two-wire match, timer B, PIT; UART, ADC, RTC if set to run.
// - Power-down: only watchdog and periodic timer with their oscillator stay on; the code holds rtc_clock_en off and blocks the PIT wake.
// - Power-down wakes only on pin change or two-wire address match.
// - Standby keeps main and RTC sources only while a running user needs them.
// - Code resumes six peripheral clocks after the main source is back.
// - Waking from idle adds no oscillator start-up delay.
// - Power-down stops all sources but low-power osc and RTC clock if used; the code stops rtc_clock_en too, rtc_osc_en follows wdt_or_bod_uses_ulp.
// - Brownout fuse active field 0x3 extends wake-up until the detector is ready.
// - Mode field bits 2:1: idle 0x0, standby 0x1, power-down 0x2, rest reserved.
// - The held mode is entered when sleep executes with sleep enable set.
// - A wake interrupt returns to active for the handler; any reset ends sleep.
// - A debug break while asleep forces active mode.
// - Register and memory contents are kept in every sleep mode.
`ifndef SLEEP_UNIT_DEFINES_VH
`define SLEEP_UNIT_DEFINES_VH

`define SLEEP_CONTROL_ADDR   12'h000
`define SLEEP_CONTROL_RESET  8'h00
`define SLEEP_ENABLE_POS     0
`define SLEEP_MODE_LSB       1
`define SLEEP_MODE_MSB       2
`define SLEEP_CONTROL_MASK   8'h07

`define MODE_IDLE            2'h0
`define MODE_STANDBY         2'h1
`define MODE_POWER_DOWN      2'h2

`define BOD_ACTIVE_WAIT      2'h3

// Wake source indices
`define WAKE_PIN             0
`define WAKE_TWO_WIRE        1
`define WAKE_TIMER_B         2
`define WAKE_UART_SOF        3
`define WAKE_ADC_WINDOW      4
`define WAKE_RTC             5
`define WAKE_PIT             6
`define WAKE_OTHER           7
`define WAKE_COUNT           8

// Run-in-standby indices
`define RUN_RTC              0
`define RUN_ADC              1
`define RUN_UART             2
`define RUN_COUNT            3

`define RESUME_CYCLES        6

`endif

// [wake_filter.v]
/*
 Wake source filter: picks which pending interrupts may end the sleep in the
 selected mode. Assumes all inputs already on pclk.
*/
`timescale 1ns/100ps
`include "sleep_unit_defines.vh"

module wake_filter
(
    input  wire [1:0]              mode,
    input  wire [`WAKE_COUNT-1:0]  wake_req,
    input  wire [`RUN_COUNT-1:0]   run_in_standby,
    output reg                     wake
);

    reg [`WAKE_COUNT-1:0] allowed;

    always @*
    begin
        allowed = {`WAKE_COUNT{1'b0}};
        case (mode)
            `MODE_IDLE:
            begin
                allowed = {`WAKE_COUNT{1'b1}};
            end
            `MODE_STANDBY:
            begin
                allowed[`WAKE_PIN]        = 1'b1;
                allowed[`WAKE_TWO_WIRE]   = 1'b1;
                allowed[`WAKE_TIMER_B]    = 1'b1;
                allowed[`WAKE_PIT]        = 1'b1;
                allowed[`WAKE_UART_SOF]   = run_in_standby[`RUN_UART];
                allowed[`WAKE_ADC_WINDOW] = run_in_standby[`RUN_ADC];
                allowed[`WAKE_RTC]        = run_in_standby[`RUN_RTC];
            end
            `MODE_POWER_DOWN:
            begin
                allowed[`WAKE_PIN]      = 1'b1;
                allowed[`WAKE_TWO_WIRE] = 1'b1;
            end
            default:
            begin
                allowed = {`WAKE_COUNT{1'b1}};
            end
        endcase
        wake = |(allowed & wake_req);
    end

endmodule

// [clock_gate_plan.v]
/*
 Clock and oscillator enables for each controller state and sleep mode.
 Assumes asleep and mode come from pclk registers.
*/
`timescale 1ns/100ps
`include "sleep_unit_defines.vh"

module clock_gate_plan
(
    input  wire                    asleep,
    input  wire [1:0]              mode,
    input  wire [`RUN_COUNT-1:0]   run_in_standby,
    input  wire                    wdt_or_bod_uses_ulp,
    output reg                     cpu_clock_en,
    output reg                     peripheral_clock_en,
    output reg                     rtc_clock_en,
    output reg                     adc_clock_en,
    output reg                     uart_clock_en,
    output reg                     main_osc_en,
    output reg                     rtc_osc_en
);

    always @*
    begin
        cpu_clock_en        = ~asleep;
        peripheral_clock_en = 1'b1;
        rtc_clock_en        = 1'b1;
        adc_clock_en        = 1'b1;
        uart_clock_en       = 1'b1;
        main_osc_en         = 1'b1;
        rtc_osc_en          = 1'b1;
        if (asleep)
        begin
            case (mode)
                `MODE_STANDBY:
                begin
                    peripheral_clock_en = 1'b0;
                    rtc_clock_en        = run_in_standby[`RUN_RTC];
                    adc_clock_en        = run_in_standby[`RUN_ADC];
                    uart_clock_en       = run_in_standby[`RUN_UART];
                    main_osc_en         = run_in_standby[`RUN_ADC] | run_in_standby[`RUN_UART];
                    rtc_osc_en          = run_in_standby[`RUN_RTC];
                end
                `MODE_POWER_DOWN:
                begin
                    peripheral_clock_en = 1'b0;
                    rtc_clock_en        = 1'b0;
                    adc_clock_en        = 1'b0;
                    uart_clock_en       = 1'b0;
                    main_osc_en         = 1'b0;
                    rtc_osc_en          = wdt_or_bod_uses_ulp;
                end
                default:
                begin
                    peripheral_clock_en = 1'b1;
                end
            endcase
        end
    end

endmodule

// [sleep_unit.v]
/*
 Sleep unit: control register on APB, sleep entry on the core's sleep
 strobe, clock gating per mode and wake-up sequencing.
 Assumes the core strobes sleep_exec for one pclk cycle, wake sources,
 debug break and oscillator/brownout ready come from other clock domains.
*/
`timescale 1ns/100ps
`include "sleep_unit_defines.vh"

module sleep_unit
#(
    parameter RESUME_CYCLES = `RESUME_CYCLES
)
(
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [11:0]             paddr,
    input  wire [31:0]             pwdata,
    input  wire [3:0]              pstrb,
    output wire                    pready,
    output reg  [31:0]             prdata,
    output wire                    pslverr,
    input  wire                    sleep_exec,
    input  wire [`WAKE_COUNT-1:0]  wake_req,
    input  wire [`RUN_COUNT-1:0]   run_in_standby,
    input  wire                    debug_break,
    input  wire                    main_osc_ready,
    input  wire                    bod_ready,
    input  wire [1:0]              bod_config_fuse,
    input  wire                    wdt_or_bod_uses_ulp,
    output reg                     core_halt,
    output reg                     sleep_done,
    output wire                    cpu_clock_en,
    output wire                    peripheral_clock_en,
    output wire                    rtc_clock_en,
    output wire                    adc_clock_en,
    output wire                    uart_clock_en,
    output wire                    main_osc_en,
    output wire                    rtc_osc_en
);

    localparam ST_ACTIVE = 3'b001;
    localparam ST_SLEEP  = 3'b010;
    localparam ST_WAKE   = 3'b100;

    //--------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------
    localparam SYNC_W = `WAKE_COUNT + 3;

    reg  [SYNC_W-1:0] sync_a;
    reg  [SYNC_W-1:0] sync_b;
    wire [`WAKE_COUNT-1:0] wake_s;
    wire              break_s;
    wire              osc_ready_s;
    wire              bod_ready_s;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= {SYNC_W{1'b0}};
            sync_b <= {SYNC_W{1'b0}};
        end
        else
        begin
            sync_a <= {wake_req, debug_break, main_osc_ready, bod_ready};
            sync_b <= sync_a;
        end
    end

    assign wake_s      = sync_b[SYNC_W-1:3];
    assign break_s     = sync_b[2];
    assign osc_ready_s = sync_b[1];
    assign bod_ready_s = sync_b[0];

    //--------------------------------------------------
    // Register bus
    //--------------------------------------------------
    reg  [7:0] sleep_control;
    wire       bus_hit;
    wire       bus_write;

    assign pready    = 1'b1;
    assign bus_hit   = (paddr == `SLEEP_CONTROL_ADDR);
    assign pslverr   = psel & penable & ~bus_hit;
    assign bus_write = psel & penable & pwrite & bus_hit & pstrb[0];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_control <= `SLEEP_CONTROL_RESET;
        end
        else if (bus_write)
        begin
            sleep_control <= pwdata[7:0] & `SLEEP_CONTROL_MASK;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel & ~penable & ~pwrite)
        begin
            prdata <= bus_hit ? {24'h000000, sleep_control} : 32'h00000000;
        end
    end

    //--------------------------------------------------
    // Sleep sequencer
    //--------------------------------------------------
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [1:0] held_mode;
    reg  [7:0] wake_count;
    wire       wake_hit;
    wire       sleep_en;
    wire [1:0] sel_mode;
    wire       osc_ok;
    wire       bod_ok;
    wire       count_done;
    reg        osc_seen;

    assign sleep_en = sleep_control[`SLEEP_ENABLE_POS];
    assign sel_mode = sleep_control[`SLEEP_MODE_MSB:`SLEEP_MODE_LSB];

    wake_filter u_wake_filter
    (
        .mode           (held_mode),
        .wake_req       (wake_s),
        .run_in_standby (run_in_standby),
        .wake           (wake_hit)
    );

    assign osc_ok = (held_mode == `MODE_IDLE) | osc_ready_s | osc_seen;
    assign bod_ok = (bod_config_fuse != `BOD_ACTIVE_WAIT) | bod_ready_s;
    // six cycles after source is back
    assign count_done = (wake_count >= RESUME_CYCLES[7:0]);

    always @*
    begin
        next_state = state;
        case (state)
            ST_ACTIVE:
            begin
                if (sleep_exec & sleep_en)
                    next_state = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (wake_hit | break_s)
                    next_state = ST_WAKE;
            end
            ST_WAKE:
            begin
                if (count_done & bod_ok)
                    next_state = ST_ACTIVE;
            end
            default:
            begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= ST_ACTIVE;
            held_mode  <= `MODE_IDLE;
            wake_count <= 8'h00;
            osc_seen   <= 1'b0;
            core_halt  <= 1'b0;
            sleep_done <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            sleep_done <= (state == ST_WAKE) & (next_state == ST_ACTIVE);
            core_halt  <= (next_state != ST_ACTIVE);
            if ((state == ST_ACTIVE) & sleep_exec & sleep_en)
                held_mode <= sel_mode;
            if (state != ST_WAKE)
            begin
                wake_count <= 8'h00;
                osc_seen   <= 1'b0;
            end
            else if (osc_ok)
            begin
                osc_seen <= 1'b1;
                if (!count_done)
                    wake_count <= wake_count + 8'h01;
            end
        end
    end

    //--------------------------------------------------
    // Clock gating
    //--------------------------------------------------
    clock_gate_plan u_clock_gate_plan
    (
        .asleep              (state == ST_SLEEP),
        .mode                (held_mode),
        .run_in_standby      (run_in_standby),
        .wdt_or_bod_uses_ulp (wdt_or_bod_uses_ulp),
        .cpu_clock_en        (cpu_clock_en),
        .peripheral_clock_en (peripheral_clock_en),
        .rtc_clock_en        (rtc_clock_en),
        .adc_clock_en        (adc_clock_en),
        .uart_clock_en       (uart_clock_en),
        .main_osc_en         (main_osc_en),
        .rtc_osc_en          (rtc_osc_en)
    );

endmodule

// [sleep_unit_sva.sv]
/* Assertions on the sleep_unit ports.
   Assumes one pclk domain; bound to every sleep_unit. */
`timescale 1ns/100ps
module sleep_unit_sva
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        sleep_exec,
    input wire        debug_break,
    input wire        wdt_or_bod_uses_ulp,
    input wire        core_halt,
    input wire        sleep_done,
    input wire        cpu_clock_en,
    input wire        peripheral_clock_en,
    input wire        rtc_clock_en,
    input wire        adc_clock_en,
    input wire        uart_clock_en,
    input wire        main_osc_en,
    input wire        rtc_osc_en,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [7:0]  wake_req,
    input wire [2:0]  run_in_standby,
    input wire [1:0]  bod_config_fuse
);
reg  [2:0] ctl;
reg  [1:0] mq;
wire       zz = !cpu_clock_en;
wire       go = sleep_exec && !core_halt && ctl[0];
// ----
// Control shadow and entered mode
// ----
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        ctl <= 3'h0;
    else if (psel && penable && pwrite && paddr == 12'h000 && pstrb[0])
        ctl <= pwdata[2:0];
end
always @(posedge pclk)
begin
    if (go)
        mq <= ctl[2:1];
end
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
property p_enter; go |=> core_halt && zz; endproperty
a_enter: assert property (p_enter) else $error("sleep not entered");
property p_noop; sleep_exec && !core_halt && !ctl[0] |=> !core_halt; endproperty
a_noop: assert property (p_noop) else $error("sleep without enable");
property p_idle; zz && mq == 2'h0 |-> peripheral_clock_en && main_osc_en && rtc_osc_en; endproperty
a_idle: assert property (p_idle) else $error("idle gated a clock");
property p_stby; zz && mq == 2'h1 |-> {uart_clock_en, adc_clock_en, rtc_clock_en} == run_in_standby
    && main_osc_en == (run_in_standby[1] || run_in_standby[2]); endproperty
a_stby: assert property (p_stby) else $error("standby gating wrong");
property p_pdn; zz && mq == 2'h2 |-> !peripheral_clock_en && !main_osc_en && !adc_clock_en
    && !(rtc_osc_en && !wdt_or_bod_uses_ulp); endproperty
a_pdn: assert property (p_pdn) else $error("power-down left a clock on");
property p_pwake; (zz && mq == 2'h2 && wake_req[1:0] == 2'h0 && !debug_break)[*4] |=> zz; endproperty
a_pwake: assert property (p_pwake) else $error("power-down woke wrongly");
property p_hold; $rose(cpu_clock_en) |-> core_halt[*6] ##[1:400] !core_halt; endproperty
a_hold: assert property (p_hold) else $error("resume count wrong");
property p_fast; $rose(cpu_clock_en) && mq == 2'h0 && bod_config_fuse != 2'h3 |-> ##[6:8] !core_halt; endproperty
a_fast: assert property (p_fast) else $error("idle wake too slow");
property p_dbg; $rose(debug_break) && zz |-> ##[1:5] cpu_clock_en; endproperty
a_dbg: assert property (p_dbg) else $error("break did not wake");
property p_done; sleep_done == $fell(core_halt); endproperty
a_done: assert property (p_done) else $error("return pulse wrong");
property p_rst; $rose(presetn) |-> !core_halt; endproperty
a_rst: assert property (p_rst) else $error("asleep after reset");
c_pdn: cover property (go && ctl[2:1] == 2'h2);
c_wake: cover property (sleep_done);
c_dbg: cover property ($rose(debug_break) && zz);
endmodule
bind sleep_unit sleep_unit_sva u_sva
(
    .pclk, .presetn, .psel, .penable, .pwrite, .sleep_exec, .debug_break, .wdt_or_bod_uses_ulp,
    .core_halt, .sleep_done, .cpu_clock_en, .peripheral_clock_en, .rtc_clock_en, .adc_clock_en,
    .uart_clock_en, .main_osc_en, .rtc_osc_en, .paddr, .pwdata, .pstrb, .wake_req,
    .run_in_standby, .bod_config_fuse
);

// [core_partner.sv]
/* Core sleep strobe and main oscillator model.
   Assumes the bench raises go for one cycle. */
`timescale 1ns/100ps
module core_partner
#(
    parameter OSC_START = 12
)
(
    input  wire pclk,
    input  wire go,
    input  wire main_osc_en,
    output reg  sleep_exec = 1'b0,
    output reg  main_osc_ready = 1'b0
);
integer n = 0;
always @(posedge pclk)
begin
    sleep_exec <= go && !sleep_exec;
    n <= main_osc_en ? n + 1 : 0;
    main_osc_ready <= main_osc_en && n >= OSC_START;
end
endmodule

// [tb_top.sv]
/* Bench for sleep_unit: control register, sleep per mode, wake sources.
   Assumes core_partner models the core and main oscillator. */
`timescale 1ns/100ps
module tb_top;
localparam OSC = 12;
logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, rd;
logic [3:0]  pstrb = 4'h0;
logic [7:0]  wake_req = 8'h00;
logic [2:0]  run_in_standby = 3'h0;
logic        debug_break = 1'b0, bod_ready = 1'b1, wdt_or_bod_uses_ulp = 1'b0, go = 1'b0, er;
logic [1:0]  bod_config_fuse = 2'h0;
wire         pready, pslverr, sleep_exec, main_osc_ready, core_halt, sleep_done, cpu_clock_en;
wire         main_osc_en, peripheral_clock_en, rtc_clock_en, adc_clock_en, uart_clock_en, rtc_osc_en;
wire [6:0]   clk_ens = {cpu_clock_en, peripheral_clock_en, rtc_clock_en, adc_clock_en, uart_clock_en,
                        main_osc_en, rtc_osc_en};
wire [31:0]  prdata;
integer      bad_count = 0, num_checks = 0, i, n;
// Row: expected enables while halted, control, run_in_standby, blocked, waking, fuse, break, ulp
logic [32:0] row;
logic [32:0] rows [0:9] = '{
    {7'h3F, 3'h1, 3'h0, 8'h00, 8'h80, 2'h0, 1'h0, 1'h0}, {7'h00, 3'h3, 3'h0, 8'hB8, 8'h04, 2'h0, 1'h0, 1'h0},
    {7'h11, 3'h3, 3'h1, 8'h98, 8'h20, 2'h0, 1'h0, 1'h0}, {7'h0E, 3'h3, 3'h6, 8'hA0, 8'h08, 2'h0, 1'h0, 1'h0},
    {7'h0A, 3'h3, 3'h2, 8'h00, 8'h10, 2'h0, 1'h0, 1'h0}, {7'h00, 3'h3, 3'h0, 8'h00, 8'h40, 2'h0, 1'h0, 1'h0},
    {7'h01, 3'h5, 3'h0, 8'hFC, 8'h01, 2'h0, 1'h0, 1'h1}, {7'h00, 3'h5, 3'h7, 8'hFC, 8'h02, 2'h0, 1'h0, 1'h0},
    {7'h00, 3'h5, 3'h0, 8'h00, 8'h00, 2'h0, 1'h1, 1'h0}, {7'h7F, 3'h1, 3'h0, 8'h01, 8'h01, 2'h3, 1'h0, 1'h0}};
sleep_unit u_dut
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .sleep_exec, .wake_req, .run_in_standby, .debug_break, .main_osc_ready,
    .bod_ready, .bod_config_fuse, .wdt_or_bod_uses_ulp, .core_halt, .sleep_done, .cpu_clock_en,
    .peripheral_clock_en, .rtc_clock_en, .adc_clock_en, .uart_clock_en,
    .main_osc_en, .rtc_osc_en
);
core_partner #(.OSC_START(OSC)) u_core (.pclk, .go, .main_osc_en, .sleep_exec, .main_osc_ready);
always #5 pclk = ~pclk;
task chk(input logic [31:0] got, input logic [31:0] exp);
begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
        bad_count = bad_count + 1;
        $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
        @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
end
endtask
task nap;
begin
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
end
endtask
task give_verdict;
begin
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
end
endtask
initial
begin
    #100000;
    bad_count = bad_count + 1;
    give_verdict;
end
initial
begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(er, 1'b0);
    for (i = 0; i < 10; i = i + 1)
    begin
        row = rows[i];
        run_in_standby <= row[22:20];
        bod_config_fuse <= row[3:2];
        wdt_or_bod_uses_ulp <= row[0];
        bod_ready <= 1'b0;
        apb(1'b1, 12'h000, {29'h0, row[25:23]}, 4'hF);
        nap;
        wake_req <= row[19:12];
        repeat (20) @(posedge pclk);
        chk(core_halt, 1'b1);
        chk(clk_ens, row[32:26]);
        wake_req <= row[11:4];
        debug_break <= row[1];
        bod_ready <= 1'b1;
        n = 0;
        while (sleep_done !== 1'b1 && n < 300)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        chk(n < 300, 1'b1);
        if (row[25:24] == 2'h0)
            chk(n <= 13, 1'b1);
        if (row[25:24] == 2'h2)
            chk(n >= OSC + 6, 1'b1);
        wake_req <= 8'h00;
        debug_break <= 1'b0;
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk(rd, {29'h0, row[25:23]});
        $display("row %0d done", i);
    end
    apb(1'b1, 12'h000, 32'hFFFFFFFF, 4'hF);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk(rd, 32'h7);
    apb(1'b1, 12'h000, 32'h0, 4'hE);
    apb(1'b1, 12'h004, 32'h0, 4'hF);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk(rd, 32'h7);
    $display("register test done");
    apb(1'b1, 12'h000, 32'h4, 4'hF);
    nap;
    repeat (3) @(posedge pclk);
    chk(core_halt, 1'b0);
    apb(1'b1, 12'h000, 32'h5, 4'hF);
    nap;
    repeat (4) @(posedge pclk);
    chk(core_halt, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(core_halt, 1'b0);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    give_verdict;
end
endmodule
